//--- hw/acm_ctrl.sv
// Continuous-mode, filter and settling control of the accelerometer sampling chain.
// Assumes register requests arrive already decoded and synchronous to clk.
`timescale 1ns/10ps
module acm_ctrl #(
  parameter int unsigned CYC_PER_US = acm_pkg::ACM_CLK_MHZ,
  parameter int unsigned PD_APPLY_CYC = acm_pkg::ACM_PD_APPLY_US * acm_pkg::ACM_CLK_MHZ,
  parameter int unsigned STOP_CYC = acm_pkg::ACM_STOP_US * acm_pkg::ACM_CLK_MHZ,
  parameter int unsigned WR_GAP_CYC = acm_pkg::ACM_WR_GAP_US * acm_pkg::ACM_CLK_MHZ
) (
  input wire logic clk,
  input wire logic nrst,
  input wire acm_pkg::acm_req_t req,
  output logic [7:0] rdata,
  output logic wr_ready,
  output acm_pkg::acm_mode_t mode,
  output logic sample_tick,
  output logic sample_ok,
  output logic aaf_en,
  output logic lpf_en,
  output logic [12:0] cutoff_q8,
  output logic [4:0] discard_left,
  output logic sampling_active,
  output logic apply_busy
);
  import acm_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acm_cfg_t cur_q, cur_d, new_c;
  acm_mode_t cur_m, new_m;
  logic hp_q, hp_d;
  logic [7:0] pmc_q, pmc_d, rrc_q, rrc_d, rd_q, rd_d;
  logic pend_q, pend_d, tick_q, tick_d, ok_q, ok_d;
  logic [31:0] tmr_q, tmr_d, smp_q, smp_d, stop_q, stop_d, gap_q, gap_d;
  logic [31:0] per_cyc, apply_cyc;
  logic [4:0] disc_q, disc_d;
  logic [12:0] cut_q, cut_d, shifted;
  logic apply, pd_settled, wr_ok;

  // A code with the HP select set still decodes as ultralow-power.
  assign cur_m = acm_mode(cur_q.rate, hp_q);
  assign new_c = '{rate: rrc_q[ACM_RATE_LSB +: 4], bw: rrc_q[ACM_BW_LSB +: 2]};
  assign new_m = acm_mode(new_c.rate, hp_q);
  assign per_cyc = 32'(acm_period_us(cur_q.rate) * CYC_PER_US);
  // A staged rate write waits one output period, or the power-down figure.
  assign apply_cyc = (cur_m == ACM_PD) ? PD_APPLY_CYC : per_cyc;
  assign apply = pend_q && (tmr_q >= apply_cyc - 32'd1);
  assign pd_settled = (cur_m == ACM_PD) && (stop_q == 32'd0);
  // Writes are refused while a rate write is staged, and for a guard time
  // after power-down settles, so a slow host cannot corrupt the stop.
  assign wr_ok = !pend_q && (!pd_settled || gap_q == WR_GAP_CYC);
  // Widened first so that code 11 shifts by four and not by zero.
  assign shifted = acm_rate_q8(cur_q.rate) >> ({1'b0, cur_q.bw} + 3'd1);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    cur_d = cur_q;
    hp_d = hp_q;
    pmc_d = pmc_q;
    rrc_d = rrc_q;
    rd_d = rd_q;
    pend_d = pend_q;
    tmr_d = pend_q ? tmr_q + 32'd1 : 32'd0;
    disc_d = disc_q;
    smp_d = smp_q;
    tick_d = 1'b0;
    stop_d = (stop_q != 32'd0) ? stop_q - 32'd1 : 32'd0;
    gap_d = !pd_settled ? 32'd0 : (gap_q == WR_GAP_CYC) ? gap_q : gap_q + 32'd1;
    if (req.rd) begin
      if (req.addr == ACM_PMC_ADDR) begin
        rd_d = pmc_q;
        rd_d[ACM_HP_BIT] = hp_q;
      end else if (req.addr == ACM_RRC_ADDR) begin
        rd_d = rrc_q;
      end else begin
        rd_d = 8'h00;
      end
    end
    if (req.wr && wr_ok) begin
      if (req.addr == ACM_RRC_ADDR) begin
        rrc_d = req.wdata;
        pend_d = 1'b1;
        tmr_d = 32'd0;
      end else if (req.addr == ACM_PMC_ADDR) begin
        pmc_d = req.wdata;
        // The HP select only moves in settled power-down.
        if (pd_settled) begin
          hp_d = req.wdata[ACM_HP_BIT];
        end
      end
    end
    // Samples repeat at the selected rate in every continuous mode.
    if (cur_m != ACM_PD) begin
      tick_d = (smp_q >= per_cyc - 32'd1);
      smp_d = tick_d ? 32'd0 : smp_q + 32'd1;
    end
    // Each sample before the count runs out is still settling.
    if (tick_d && disc_q != 5'd0) begin
      disc_d = disc_q - 5'd1;
    end
    if (apply) begin
      pend_d = 1'b0;
      cur_d = new_c;
      // Configuration is kept in power-down; sampling stops and both filters switch off with the cutoff at zero.
      if (new_c != cur_q) begin
        smp_d = 32'd0;
        tick_d = 1'b0;
        // A fresh count replaces whatever was left.
        case (new_m)
          ACM_ULP: disc_d = 5'd0;
          ACM_LP: disc_d = acm_lp_settle(new_c) + {4'd0, cur_m == ACM_ULP};
          ACM_HP: disc_d = acm_hp_settle(new_c)
            + {4'd0, cur_m == ACM_HP && new_c.rate != cur_q.rate};
          default: disc_d = 5'd0;
        endcase
        // Stepping out of 1011 is the host's job; the stop window is ours.
        if (cur_m != ACM_PD && new_m == ACM_PD) begin
          stop_d = STOP_CYC;
        end
      end
    end
  end

  // Filter chain steering follows the applied mode.
  always_comb begin
    case (cur_m)
      ACM_ULP: cut_d = ACM_ULP_CUT_Q8;
      ACM_LP: cut_d = (shifted < ACM_LP_FLOOR_Q8) ? ACM_LP_FLOOR_Q8 : shifted;
      ACM_HP: cut_d = shifted;
      default: cut_d = 13'h0000;
    endcase
    // The tick that uses up the count is itself still a discarded sample.
    ok_d = tick_d && (disc_q == 5'd0);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cur_q <= '0;
      hp_q <= 1'b0;
      pmc_q <= ACM_PMC_RST;
      rrc_q <= ACM_RRC_RST;
      rd_q <= 8'h00;
      pend_q <= 1'b0;
      tmr_q <= 32'd0;
      smp_q <= 32'd0;
      stop_q <= 32'd0;
      gap_q <= 32'd0;
      disc_q <= 5'd0;
      tick_q <= 1'b0;
      ok_q <= 1'b0;
      cut_q <= 13'h0000;
    end else begin
      cur_q <= cur_d;
      hp_q <= hp_d;
      pmc_q <= pmc_d;
      rrc_q <= rrc_d;
      rd_q <= rd_d;
      pend_q <= pend_d;
      tmr_q <= tmr_d;
      smp_q <= smp_d;
      stop_q <= stop_d;
      gap_q <= gap_d;
      disc_q <= disc_d;
      tick_q <= tick_d;
      ok_q <= ok_d;
      cut_q <= cut_d;
    end
  end

  assign rdata = rd_q;
  assign wr_ready = wr_ok;
  assign mode = cur_m;
  assign sample_tick = tick_q;
  assign sample_ok = ok_q;
  assign aaf_en = (cur_m == ACM_LP) || (cur_m == ACM_HP);
  assign lpf_en = aaf_en;
  assign cutoff_q8 = cut_q;
  assign discard_left = disc_q;
  assign sampling_active = (cur_m != ACM_PD) || (stop_q != 32'd0);
  assign apply_busy = pend_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_pd_no_samples: assert property (
    cur_q.rate == ACM_RATE_PD && $past(cur_q.rate) == ACM_RATE_PD |-> !tick_q)
    else $error("sample produced in power-down");
  a_filters_on: assert property (
    hp_q == 1'b0 && cur_q.rate > ACM_RATE_ULP_MAX && cur_q.rate <= ACM_RATE_CONT_MAX
    |-> aaf_en && lpf_en && cur_m == ACM_LP)
    else $error("filters off in low-power");
  a_ulp_no_discard: assert property (
    apply && new_c != cur_q && new_m == ACM_ULP |=> disc_q == 5'd0)
    else $error("discard set on ultralow-power entry");
  a_hp_extra_one: assert property (
    apply && cur_m == ACM_HP && new_m == ACM_HP && new_c.rate != cur_q.rate
    |=> disc_q == acm_hp_settle(cur_q) + 5'd1)
    else $error("HP rate change discard wrong");
  a_ulp_lp_extra: assert property (
    apply && cur_m == ACM_ULP && new_m == ACM_LP |=> disc_q == acm_lp_settle(cur_q) + 5'd1)
    else $error("ultralow to low-power discard wrong");
  a_stop_window: assert property (
    apply && cur_m != ACM_PD && new_m == ACM_PD |=> stop_q == STOP_CYC ##1 sampling_active[*8])
    else $error("stop window missing");
  a_settled_only: assert property (
    sample_ok |-> sample_tick && $past(disc_q) == 5'd0)
    else $error("unsettled sample flagged ok");
  a_apply_hold: assert property (
    pend_q && tmr_q < apply_cyc - 32'd1 |=> pend_q && cur_q == $past(cur_q))
    else $error("rate write applied early");
  a_lp_floor: assert property (
    cur_m == ACM_LP |=> cutoff_q8 >= ACM_LP_FLOOR_Q8)
    else $error("low-power cutoff below floor");
  a_hp_locked: assert property (
    !pd_settled |=> hp_q == $past(hp_q))
    else $error("HP select moved outside power-down");

  c_hp_rate_change: cover property (apply && cur_m == ACM_HP && new_m == ACM_HP);
  c_ulp_to_lp: cover property (apply && cur_m == ACM_ULP && new_m == ACM_LP);
  c_power_down: cover property (apply && cur_m != ACM_PD && new_m == ACM_PD);
  c_settled: cover property (sample_ok);

endmodule

//--- hw/acm_pkg.sv
// Constants, types and lookup functions for the accelerometer continuous-mode control.
// Assumes a single 50 MHz clock and register access from an already decoded serial host port.
package acm_pkg;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ACM_PMC_ADDR = 8'h12;
  localparam logic [7:0] ACM_RRC_ADDR = 8'h14;
  localparam logic [7:0] ACM_PMC_RST = 8'h00;
  localparam logic [7:0] ACM_RRC_RST = 8'h00;
  localparam int ACM_HP_BIT = 2;
  localparam int ACM_RATE_LSB = 4;
  localparam int ACM_BW_LSB = 2;
  localparam logic [3:0] ACM_RATE_PD = 4'h0;
  localparam logic [3:0] ACM_RATE_ULP_MAX = 4'h3;
  localparam logic [3:0] ACM_RATE_CONT_MAX = 4'hb;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ACM_CLK_MHZ = 50;
  localparam int ACM_PD_APPLY_US = 500;
  localparam int ACM_STOP_US = 2000;
  localparam int ACM_WR_GAP_US = 100;
  localparam logic [12:0] ACM_LP_FLOOR_Q8 = 13'h0018;
  localparam logic [12:0] ACM_ULP_CUT_Q8 = 13'h0c80;

  typedef enum logic [1:0] {ACM_PD, ACM_ULP, ACM_LP, ACM_HP} acm_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } acm_req_t;

  typedef struct packed {
    logic [3:0] rate;
    logic [1:0] bw;
  } acm_cfg_t;

  // Codes above the continuous range are treated as power-down.
  function automatic acm_mode_t acm_mode(input logic [3:0] rate, input logic hp);
    if (rate == ACM_RATE_PD || rate > ACM_RATE_CONT_MAX) return ACM_PD;
    else if (rate <= ACM_RATE_ULP_MAX) return ACM_ULP;
    else if (hp) return ACM_HP;
    else return ACM_LP;
  endfunction

  // Output period in microseconds.
  function automatic logic [19:0] acm_period_us(input logic [3:0] rate);
    case (rate)
      4'h1: return 20'h98968;
      4'h2: return 20'h51615;
      4'h3: return 20'h09c40;
      4'h4: return 20'h28b0b;
      4'h5: return 20'h13880;
      4'h6: return 20'h09c40;
      4'h7: return 20'h04e20;
      4'h8: return 20'h02710;
      4'h9: return 20'h01388;
      4'ha: return 20'h009c4;
      4'hb: return 20'h004e2;
      default: return 20'h001f4;
    endcase
  endfunction

  // Output rate in eighths of a hertz.
  function automatic logic [12:0] acm_rate_q8(input logic [3:0] rate);
    case (rate)
      4'h1: return 13'h000d;
      4'h2: return 13'h0018;
      4'h3: return 13'h00c8;
      4'h4: return 13'h0030;
      4'h5: return 13'h0064;
      4'h6: return 13'h00c8;
      4'h7: return 13'h0190;
      4'h8: return 13'h0320;
      4'h9: return 13'h0640;
      4'ha: return 13'h0c80;
      4'hb: return 13'h1900;
      default: return 13'h0000;
    endcase
  endfunction

  // Rows hold the counts for bandwidth codes 11, 10, 01, 00.
  function automatic logic [4:0] acm_lp_settle(input acm_cfg_t c);
    logic [19:0] row;
    case (c.rate)
      4'h5: row = {5'h06, 5'h03, 5'h03, 5'h03};
      4'h6: row = {5'h0a, 5'h06, 5'h03, 5'h03};
      4'h7, 4'h8: row = {5'h14, 5'h0a, 5'h06, 5'h03};
      4'h9: row = {5'h14, 5'h09, 5'h05, 5'h03};
      4'ha: row = {5'h10, 5'h08, 5'h04, 5'h02};
      4'hb: row = {5'h0e, 5'h06, 5'h02, 5'h02};
      default: row = {5'h03, 5'h03, 5'h03, 5'h03};
    endcase
    return row[5*c.bw +: 5];
  endfunction

  function automatic logic [4:0] acm_hp_settle(input acm_cfg_t c);
    logic [19:0] row;
    case (c.rate)
      4'h8, 4'h9: row = {5'h14, 5'h08, 5'h03, 5'h02};
      4'ha: row = {5'h14, 5'h07, 5'h03, 5'h02};
      4'hb: row = {5'h12, 5'h07, 5'h03, 5'h02};
      default: row = {5'h14, 5'h09, 5'h03, 5'h02};
    endcase
    return row[5*c.bw +: 5];
  endfunction

endpackage

//--- tb/accel_continuous_mode_control_bench.sv
// Self-checking bench for the continuous-mode control, driven through the host model.
// Assumes shortened apply, stop and gap counts so the slow rates fit in one run.
`timescale 1ns/10ps
module accel_continuous_mode_control_bench;
  import acm_pkg::*;
  localparam int PD_CYC = 20;
  localparam int STOP = 16;
  logic clk;
  logic nrst;
  acm_req_t req;
  logic [7:0] rdata;
  logic wr_ready;
  acm_mode_t mode;
  logic sample_tick;
  logic sample_ok;
  logic aaf_en;
  logic lpf_en;
  logic [12:0] cutoff_q8;
  logic [4:0] discard_left;
  logic sampling_active;
  logic apply_busy;
  int n_mismatch = 0;
  int compares = 0;

  acm_ctrl #(.CYC_PER_US(1), .PD_APPLY_CYC(PD_CYC), .STOP_CYC(STOP), .WR_GAP_CYC(10))
    acm_ctrl_inst (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata), .wr_ready(wr_ready),
    .mode(mode), .sample_tick(sample_tick), .sample_ok(sample_ok), .aaf_en(aaf_en),
    .lpf_en(lpf_en), .cutoff_q8(cutoff_q8), .discard_left(discard_left),
    .sampling_active(sampling_active), .apply_busy(apply_busy));

  acm_host acm_host_inst (.clk(clk), .wr_ready(wr_ready), .rdata(rdata), .req(req));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    acm_host_inst.wr(a, d, ok);
    if (ok !== 1'b1) begin
      n_mismatch++;
      print_verdict();
    end
  endtask

  task automatic r(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    acm_host_inst.rd(a, d);
    check(20'(d), 20'(exp));
  endtask

  // Waits out the staged apply of a rate write; a hang ends the run.
  task automatic settle();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (apply_busy === 1'b1 && n < 60000);
    if (apply_busy !== 1'b0) begin
      n_mismatch++;
      print_verdict();
    end
    // The cutoff register follows the applied mode one cycle later.
    @(posedge clk);
    #1;
  endtask

  // Cutoff is the rate divided by 2, 4, 8 or 16, in eighths of a hertz.
  function automatic logic [12:0] cut(input int hz8, input int bw);
    return 13'(hz8 >> (bw + 1));
  endfunction

  task automatic expect_cfg(input acm_mode_t m, input logic f, input logic [12:0] c,
                            input logic [4:0] d);
    check(20'(mode), 20'(m));
    check(20'(aaf_en), 20'(f));
    check(20'(lpf_en), 20'(f));
    check(20'(cutoff_q8), 20'(c));
    check(20'(discard_left), 20'(d));
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    int nt;
    int t0;
    int gap;
    nrst = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    check(20'(wr_ready), 20'h0);
    expect_cfg(ACM_PD, 1'b0, 13'h0, 5'h0);
    r(8'h12, 8'h00);
    r(8'h20, 8'h00);
    w(8'h12, 8'h04);
    r(8'h12, 8'h04);
    w(8'h14, 8'hb4);
    settle();
    expect_cfg(ACM_HP, 1'b1, cut(6400, 1), 5'h03);
    check(20'(sampling_active), 20'h1);
    // Tick spacing at 800 Hz and the count of ticks up to and including the first good one.
    n = 0;
    nt = 0;
    t0 = 0;
    gap = 0;
    while (sample_ok !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
      if (sample_tick === 1'b1) begin
        nt++;
        if (nt == 2) gap = n - t0;
        t0 = n;
      end
    end
    check(20'(gap), 20'(1250));
    check(20'(nt), 20'd4);
    w(8'h12, 8'h00);
    r(8'h12, 8'h04);
    w(8'h14, 8'ha4);
    settle();
    expect_cfg(ACM_HP, 1'b1, cut(3200, 1), 5'h04);
    repeat (3000) @(posedge clk);
    w(8'h14, 8'h00);
    settle();
    expect_cfg(ACM_PD, 1'b0, 13'h0, 5'h0);
    check(20'(sampling_active), 20'h1);
    repeat (STOP + 2) @(posedge clk);
    #1;
    check(20'(sampling_active), 20'h0);
    r(8'h12, 8'h04);
    w(8'h12, 8'h00);
    w(8'h14, 8'h30);
    settle();
    expect_cfg(ACM_ULP, 1'b0, 13'hc80, 5'h0);
    w(8'h14, 8'h9c);
    settle();
    expect_cfg(ACM_LP, 1'b1, cut(1600, 3), 5'd21);
    print_verdict();
  end
endmodule

//--- tb/acm_host.sv
// Host-side model that drives the register request port of the mode control.
// Assumes the bench calls its tasks from one process, one request at a time.
`timescale 1ns/10ps
module acm_host
  import acm_pkg::*;
(
  input wire logic clk,
  input wire logic wr_ready,
  input wire logic [7:0] rdata,
  output acm_pkg::acm_req_t req
);
  initial req = '0;

  // Holds the write until an edge at which the device takes it, so a refused write is
  // never lost silently.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    do begin
      @(negedge clk);
      ok = (wr_ready === 1'b1);
      @(posedge clk);
      n++;
    end while (!ok && n < 60000);
    req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1;
    d = rdata;
  endtask
endmodule
